// ---- include/ssr_defs.svh ----
// constants shared by both ends of the synchronous serial receive link
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

`define SSR_BITS        8
`define SSR_CNT_W       3
`define SSR_DIV_W       6
`define SSR_DIV_ONE     6'h01
`define SSR_DIV_EIGHT   6'h08
`define SSR_DIV_TT      6'h20
`define SSR_SEL_ONE     2'h0
`define SSR_SEL_EIGHT   2'h1
`define SSR_SEL_TT      2'h2
`define SSR_HALF_DEF    4
`define SSR_BYTE_RST    8'h00
`define SSR_PIN_IDLE    1'b1
`define SSR_CH_MAX      2

`endif

// ---- include/ssr_link_if.sv ----
// link wires between the receiving device and the external transmitter
`timescale 1ns/1ps
interface ssr_link_if;
   logic rx_clk_out;      // device drives the clock pin (internal clock)
   logic rx_clk_oe;
   logic tx_clk_out;      // far party drives the clock pin (external clock)
   logic tx_clk_oe;
   logic shift_clock_pin;
   logic serial_in_pin;
   logic serial_out_pin;
   logic recv_ready_out;
   logic clock_aux_out;

   // resolved clock pin level, pulled high when nobody drives it
   assign shift_clock_pin = rx_clk_oe ? rx_clk_out : (tx_clk_oe ? tx_clk_out : 1'b1);

   modport rx_end (
      output rx_clk_out,
      output rx_clk_oe,
      input  shift_clock_pin,
      input  serial_in_pin,
      output serial_out_pin,
      output recv_ready_out,
      output clock_aux_out
   );

   modport tx_end (
      output tx_clk_out,
      output tx_clk_oe,
      input  shift_clock_pin,
      output serial_in_pin,
      input  serial_out_pin,
      input  recv_ready_out
   );
endinterface

// ---- include/ssr_pkg.sv ----
// types shared by both ends of the synchronous serial receive link
package ssr_pkg;

   typedef logic [7:0] ssr_byte_t;

   typedef enum logic [1:0] {
      SSR_SND_IDLE,
      SSR_SND_WAIT,
      SSR_SND_SHIFT
   } ssr_snd_state_t;

endpackage

// ---- rtl/ssr_receiver.sv ----
// receiving end: clock-synchronous serial reception with handshake output
`timescale 1ns/1ps
`include "ssr_defs.svh"

module ssr_receiver #(
   parameter int CHANNEL      = 0,
   parameter bit SPLIT_ON_CH0 = 1'b0
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              recv_enable,
   input  wire logic              xmit_enable,
   input  wire logic              clk_ext_sel,
   input  wire logic              clk_polarity,
   input  wire logic [1:0]        clk_div_sel,
   input  wire logic              rts_func_en,
   input  wire logic              rts_disable,
   input  wire logic              clk_multi_sel,
   input  wire logic              peer_split_sel,
   input  wire logic              dummy_wr,
   input  wire ssr_pkg::ssr_byte_t dummy_data,
   input  wire logic              rbuf_rd,
   input  wire logic              irq_ack,
   output ssr_pkg::ssr_byte_t     rbuf_data,
   output logic                   recv_done_flag,
   output logic                   overrun_flag,
   output logic                   recv_irq,
   output logic                   tbuf_empty,
   ssr_link_if.rx_end             link
);

   // refuse channel numbers and pin options the logic cannot serve
   if (CHANNEL < 0 || CHANNEL > `SSR_CH_MAX) begin : g_bad_ch
      $error("channel number out of range");
   end
   if (SPLIT_ON_CH0 && CHANNEL != 0) begin : g_bad_split
      $error("separated handshake pins exist on channel zero only");
   end

   // divider limit for the internal transfer clock half period
   function automatic logic [`SSR_DIV_W-1:0] div_limit(input logic [1:0] sel);
      case (sel)
         `SSR_SEL_ONE:   div_limit = `SSR_DIV_ONE;
         `SSR_SEL_EIGHT: div_limit = `SSR_DIV_EIGHT;
         default:        div_limit = `SSR_DIV_TT;
      endcase
   endfunction

   logic                   ext_clk_s;
   logic                   rx_s;
   logic                   prev_reg;
   logic                   sclk_reg;
   logic [`SSR_DIV_W-1:0]  div_cnt_reg;
   logic                   busy_reg;
   logic [`SSR_CNT_W-1:0]  bit_cnt_reg;
   ssr_pkg::ssr_byte_t     tbuf_reg;
   ssr_pkg::ssr_byte_t     txsh_reg;
   ssr_pkg::ssr_byte_t     rxsh_reg;
   logic                   multi_ok;
   logic                   hs_avail;
   logic                   ready;
   logic                   start;
   logic                   int_tog;
   logic                   rise;
   logic                   fall;
   logic                   samp;
   logic                   outg;
   logic                   done;
   logic                   ovr_hit;
   logic                   idle_lvl;

   // pin inputs pass four flops before use
   ssr_sync #(.RST_VAL(`SSR_PIN_IDLE)) u_clk_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pin   (link.shift_clock_pin),
      .level (ext_clk_s)
   );

   ssr_sync #(.RST_VAL(`SSR_PIN_IDLE)) u_dat_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pin   (link.serial_in_pin),
      .level (rx_s)
   );

   // mode decode: multi-pin clock and handshake availability
   assign multi_ok = (CHANNEL == 1) && clk_multi_sel && !clk_ext_sel && rts_disable;
   assign hs_avail = rts_func_en && clk_ext_sel && !rts_disable && !multi_ok
                     && !((CHANNEL == 1) && peer_split_sel);
   assign idle_lvl = !clk_polarity;

   // reception may start once both enables are on and dummy data waits
   assign ready = recv_enable && xmit_enable && !tbuf_empty;
   assign start = ready && !busy_reg;

   // internal clock toggles at the end of each divided half period
   assign int_tog = busy_reg && !clk_ext_sel
                    && (div_cnt_reg == div_limit(clk_div_sel) - `SSR_DIV_W'(1));

   // transfer clock edges from the selected source
   assign rise = clk_ext_sel ? (ext_clk_s && !prev_reg) : (int_tog && !sclk_reg);
   assign fall = clk_ext_sel ? (!ext_clk_s && prev_reg) : (int_tog && sclk_reg);
   assign samp = busy_reg && (clk_polarity ? fall : rise);
   assign outg = busy_reg && (clk_polarity ? rise : fall);
   assign done = samp && (bit_cnt_reg == `SSR_CNT_W'(`SSR_BITS - 1));
   assign ovr_hit = done && recv_done_flag && !rbuf_rd;

   // previous synchronised external clock level for edge detection
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= `SSR_PIN_IDLE;
      end else begin
         prev_reg <= ext_clk_s;
      end
   end

   // internal divider and transfer clock, parked at the idle level; the pin copy
   // moves with it so output data never changes on a sampling edge at divide by one
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg     <= '0;
         sclk_reg        <= `SSR_PIN_IDLE;
         link.rx_clk_out <= `SSR_PIN_IDLE;
      end else if (!busy_reg || clk_ext_sel) begin
         div_cnt_reg     <= '0;
         sclk_reg        <= idle_lvl;                 // stops high with polarity 0
         link.rx_clk_out <= idle_lvl;
      end else if (int_tog) begin
         div_cnt_reg     <= '0;
         sclk_reg        <= !sclk_reg;
         link.rx_clk_out <= !sclk_reg;
      end else begin
         div_cnt_reg <= div_cnt_reg + `SSR_DIV_W'(1);
      end
   end

   // busy spans one byte; dropping receive enable aborts it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
      end else if (!recv_enable || done) begin
         busy_reg <= 1'b0;
      end else if (start) begin
         busy_reg <= 1'b1;
      end
   end

   // sampled bit counter, cleared for each byte
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_reg <= '0;
      end else if (start || done) begin
         bit_cnt_reg <= '0;
      end else if (samp) begin
         bit_cnt_reg <= bit_cnt_reg + `SSR_CNT_W'(1);
      end
   end

   // transmit buffer holding the dummy byte; a write wins over the take
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tbuf_reg   <= `SSR_BYTE_RST;
         tbuf_empty <= 1'b1;
      end else if (dummy_wr) begin
         tbuf_reg   <= dummy_data;
         tbuf_empty <= 1'b0;
      end else if (start) begin
         tbuf_empty <= 1'b1;
      end
   end

   // dummy byte shifted out lsb first on output edges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txsh_reg            <= `SSR_BYTE_RST;
         link.serial_out_pin <= `SSR_PIN_IDLE;
      end else if (start) begin
         txsh_reg <= tbuf_reg;
      end else if (outg) begin
         link.serial_out_pin <= txsh_reg[0];
         txsh_reg            <= txsh_reg >> 1;
      end
   end

   // receive shift register: new bit enters the msb, contents move right
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rxsh_reg <= `SSR_BYTE_RST;
      end else if (samp) begin
         rxsh_reg <= {rx_s, rxsh_reg[`SSR_BITS-1:1]};
      end
   end

   // completed byte moves to the receive buffer, overrun or not
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rbuf_data <= `SSR_BYTE_RST;
      end else if (done) begin
         rbuf_data <= {rx_s, rxsh_reg[`SSR_BITS-1:1]};
      end
   end

   // done flag: completion sets, a low-byte read clears, set wins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         recv_done_flag <= 1'b0;
      end else if (done) begin
         recv_done_flag <= 1'b1;
      end else if (rbuf_rd) begin
         recv_done_flag <= 1'b0;
      end
   end

   // overrun flag, cleared by switching reception off
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         overrun_flag <= 1'b0;
      end else if (ovr_hit) begin
         overrun_flag <= 1'b1;
      end else if (!recv_enable) begin
         overrun_flag <= 1'b0;
      end
   end

   // receive interrupt request, withheld on overrun, set wins over ack
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         recv_irq <= 1'b0;
      end else if (done && !ovr_hit) begin
         recv_irq <= 1'b1;
      end else if (irq_ack) begin
         recv_irq <= 1'b0;
      end
   end

   // request-to-send: low when hs_avail and reception is enabled, high during a byte
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         link.recv_ready_out <= 1'b1;
      end else if (!hs_avail || !recv_enable) begin
         link.recv_ready_out <= 1'b1;
      end else if (done || !busy_reg) begin
         link.recv_ready_out <= 1'b0;
      end else if (rise || fall) begin
         link.recv_ready_out <= 1'b1;
      end
   end

   // clock pin drive for the internal source, and the extra clock pin
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         link.rx_clk_oe     <= 1'b0;
         link.clock_aux_out <= `SSR_PIN_IDLE;
      end else begin
         link.rx_clk_oe     <= !clk_ext_sel;
         link.clock_aux_out <= multi_ok ? sclk_reg : `SSR_PIN_IDLE;
      end
   end

endmodule

// ---- rtl/ssr_sender.sv ----
// far end: external transmitter that drives the shift clock and data
`timescale 1ns/1ps
`include "ssr_defs.svh"
module ssr_sender #(
   parameter int HALF = `SSR_HALF_DEF
) (
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               clk_polarity,
   input  wire logic               drive_clock,
   input  wire logic               use_permit,
   input  wire ssr_pkg::ssr_byte_t send_data,
   input  wire logic               send_valid,
   output logic                    send_ready,
   ssr_link_if.tx_end              link
);

   if (HALF < 2 || HALF > 255) begin : g_bad_half
      $error("half period must lie between 2 and 255 cycles");
   end

   ssr_pkg::ssr_snd_state_t state_reg;
   ssr_pkg::ssr_byte_t      sh_reg;
   logic [7:0]              half_cnt_reg;
   logic [4:0]              tog_cnt_reg;
   logic                    permit_s;
   logic                    tog;

   // request-to-send from the receiver is a foreign pin
   ssr_sync #(.RST_VAL(1'b1)) u_permit_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pin   (link.recv_ready_out),
      .level (permit_s)
   );

   assign tog = (state_reg == ssr_pkg::SSR_SND_SHIFT)
                && (half_cnt_reg == 8'(HALF - 1));

   // byte handshake, permit wait and sixteen clock half periods
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ssr_pkg::SSR_SND_IDLE;
         send_ready   <= 1'b1;
         sh_reg       <= `SSR_BYTE_RST;
         half_cnt_reg <= '0;
         tog_cnt_reg  <= '0;
      end else begin
         case (state_reg)
            ssr_pkg::SSR_SND_IDLE: begin
               if (send_valid) begin
                  sh_reg     <= send_data;
                  send_ready <= 1'b0;
                  state_reg  <= ssr_pkg::SSR_SND_WAIT;
               end
            end
            ssr_pkg::SSR_SND_WAIT: begin
               half_cnt_reg <= '0;
               tog_cnt_reg  <= '0;
               if (!use_permit || !permit_s) begin
                  state_reg <= ssr_pkg::SSR_SND_SHIFT;
               end
            end
            ssr_pkg::SSR_SND_SHIFT: begin
               if (tog) begin
                  half_cnt_reg <= '0;
                  tog_cnt_reg  <= tog_cnt_reg + 5'h01;
                  if (!tog_cnt_reg[0]) begin
                     sh_reg <= sh_reg >> 1;
                  end
                  if (tog_cnt_reg == 5'(2 * `SSR_BITS - 1)) begin
                     send_ready <= 1'b1;
                     state_reg  <= ssr_pkg::SSR_SND_IDLE;
                  end
               end else begin
                  half_cnt_reg <= half_cnt_reg + 8'h01;
               end
            end
            default: begin
               state_reg <= ssr_pkg::SSR_SND_IDLE;
            end
         endcase
      end
   end

   // clock and data pins: data changes on the leaving edge of each bit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         link.tx_clk_oe     <= 1'b0;
         link.tx_clk_out    <= `SSR_PIN_IDLE;
         link.serial_in_pin <= `SSR_PIN_IDLE;
      end else begin
         link.tx_clk_oe <= drive_clock;
         if (state_reg != ssr_pkg::SSR_SND_SHIFT) begin
            link.tx_clk_out <= !clk_polarity;     // idle level
            link.serial_in_pin <= `SSR_PIN_IDLE;  // released data line rests high
         end else if (tog) begin
            link.tx_clk_out <= !link.tx_clk_out;
            if (!tog_cnt_reg[0]) begin
               link.serial_in_pin <= sh_reg[0];
            end
         end
      end
   end

endmodule

// ---- rtl/ssr_sync.sv ----
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module ssr_sync #(
   parameter bit RST_VAL = 1'b1
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // shift chain; only the second stage reads the first
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         level <= RST_VAL;
      end else if (s2_reg == s3_reg) begin
         level <= s3_reg;
      end
   end
endmodule

// ---- verif/ssr_link_assertions.sv ----
// concurrent checks on the link wires between the receiving end and the sender
`timescale 1ns/1ps
module ssr_link_assertions #(
   parameter int CHANNEL = 0,
   parameter int HALF    = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic rx_clk_out,
   input wire logic rx_clk_oe,
   input wire logic tx_clk_out,
   input wire logic tx_clk_oe,
   input wire logic recv_ready_out,
   input wire logic clock_aux_out
);
   localparam int PD = HALF + 1;
   logic       tx_prev;
   logic       tx_edge;
   logic       in_burst;
   logic [6:0] lo_cnt;
   logic [6:0] gap_cnt;
   logic [4:0] edge_n;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // an edge of the sender clock, and whether it belongs to a running byte
   assign tx_edge  = tx_clk_oe && (tx_clk_out != tx_prev);
   assign in_burst = gap_cnt <= 7'(PD);

   // gap since the last sender clock edge and edge count within the byte
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_prev <= 1'b1;
         gap_cnt <= 7'h7F;
         edge_n  <= 5'h00;
      end else begin
         tx_prev <= tx_clk_out;
         if (tx_edge) begin
            gap_cnt <= 7'h00;
            edge_n  <= in_burst ? edge_n + 5'h01 : 5'h01;
         end else if (gap_cnt != 7'h7F) begin
            gap_cnt <= gap_cnt + 7'h01;
         end
      end
   end

   // length of each low phase of the internal clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lo_cnt <= 7'h00;
      end else if (!rx_clk_oe || rx_clk_out) begin
         lo_cnt <= 7'h00;
      end else if (lo_cnt != 7'h7F) begin
         lo_cnt <= lo_cnt + 7'h01;
      end
   end

   int_low_phase_a: assert property (
      rx_clk_oe && rx_clk_out && lo_cnt != 7'h00 |-> lo_cnt inside {7'h01, 7'h08, 7'h20})
      else $error("internal clock low phase is not 1, 8 or 32 cycles");
   clock_park_a: assert property (
      rx_clk_oe && $fell(rx_clk_out) |-> ##[1:40] rx_clk_out)
      else $error("internal clock did not return high");
   int_no_rts_a: assert property (
      rx_clk_oe && $past(rx_clk_oe) |-> recv_ready_out)
      else $error("ready output low with internal clock");
   permit_first_a: assert property (
      tx_edge && in_burst && edge_n == 5'h01 |-> !$past(recv_ready_out, PD))
      else $error("sender clock started while ready output high");
   ready_busy_a: assert property (
      tx_edge && in_burst && edge_n inside {[5'h02:5'h0F]} |-> recv_ready_out)
      else $error("ready output low during a byte");
   ready_done_a: assert property (
      tx_edge && in_burst && edge_n == 5'h0F |-> ##[1:12] !recv_ready_out)
      else $error("ready output not low after a byte");
   bit_count_a: assert property (
      tx_edge && in_burst |-> edge_n < 5'h10)
      else $error("more than sixteen clock edges in one byte");
   aux_quiet_a: assert property (
      CHANNEL != 1 |-> clock_aux_out)
      else $error("extra clock pin active on a channel without it");
endmodule

// ---- verif/sync_serial_receiver_tb.sv ----
// self-checking bench joining the receiving end to the external sender
`timescale 1ns/1ps
module sync_serial_receiver_tb;
   typedef struct packed {
      logic       ext;
      logic       pol;
      logic [1:0] div;
      logic [7:0] tx;
      logic [7:0] dum;
   } ssr_row_t;

   localparam ssr_row_t rows [6] = '{
      '{1'b1, 1'b0, 2'h0, 8'hA5, 8'h3C}, '{1'b1, 1'b1, 2'h0, 8'h5A, 8'hC3},
      '{1'b0, 1'b0, 2'h0, 8'hFF, 8'h96}, '{1'b0, 1'b0, 2'h1, 8'hFF, 8'h71},
      '{1'b0, 1'b0, 2'h2, 8'hFF, 8'h0E}, '{1'b0, 1'b0, 2'h3, 8'hFF, 8'hE1}};

   logic               mclk = 1'b0;
   logic               rst_n, recv_enable, xmit_enable, clk_ext_sel, clk_polarity;
   logic [1:0]         clk_div_sel;
   logic               dummy_wr, rbuf_rd, irq_ack, send_valid, pin_q;
   logic               rts_func_en, rts_disable, clk_multi_sel, peer_split_sel;
   logic               tbuf_empty, send_ready;
   logic               recv_done_flag, overrun_flag, recv_irq;
   ssr_pkg::ssr_byte_t dummy_data, send_data, rbuf_data, in_cap, out_cap;
   ssr_row_t           r;
   int                 error_cnt = 0;
   int                 comparisons = 0;

   ssr_link_if link_if ();

   ssr_receiver #(.CHANNEL(0), .SPLIT_ON_CH0(1'b0)) ssr_receiver_i (
      .mclk(mclk), .rst_n(rst_n), .recv_enable(recv_enable), .xmit_enable(xmit_enable),
      .clk_ext_sel(clk_ext_sel), .clk_polarity(clk_polarity), .clk_div_sel(clk_div_sel),
      .rts_func_en(rts_func_en), .rts_disable(rts_disable), .clk_multi_sel(clk_multi_sel),
      .peer_split_sel(peer_split_sel),
      .dummy_wr(dummy_wr), .dummy_data(dummy_data), .rbuf_rd(rbuf_rd), .irq_ack(irq_ack),
      .rbuf_data(rbuf_data), .recv_done_flag(recv_done_flag), .overrun_flag(overrun_flag),
      .recv_irq(recv_irq), .tbuf_empty(tbuf_empty), .link(link_if));

   ssr_sender #(.HALF(8)) ssr_sender_i (
      .mclk(mclk), .rst_n(rst_n), .clk_polarity(clk_polarity), .drive_clock(clk_ext_sel),
      .use_permit(1'b1), .send_data(send_data), .send_valid(send_valid),
      .send_ready(send_ready),
      .link(link_if));

   ssr_link_assertions #(.CHANNEL(0), .HALF(8)) ssr_link_assertions_i (
      .mclk(mclk), .rst_n(rst_n), .rx_clk_out(link_if.rx_clk_out),
      .rx_clk_oe(link_if.rx_clk_oe), .tx_clk_out(link_if.tx_clk_out),
      .tx_clk_oe(link_if.tx_clk_oe), .recv_ready_out(link_if.recv_ready_out),
      .clock_aux_out(link_if.clock_aux_out));

   // 200 MHz clock
   always #2.5 mclk = ~mclk;

   // wire monitor: bits taken at the sampling edge of the clock pin, first bit ends lowest
   always @(negedge mclk) begin
      pin_q <= link_if.shift_clock_pin;
      if (pin_q !== link_if.shift_clock_pin && link_if.shift_clock_pin === !clk_polarity) begin
         in_cap  <= {link_if.serial_in_pin, in_cap[7:1]};
         out_cap <= {link_if.serial_out_pin, out_cap[7:1]};
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic cmp8(input ssr_pkg::ssr_byte_t got, input ssr_pkg::ssr_byte_t exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask

   task automatic wait_flag(input logic ovr);
      int n;
      n = 0;
      while ((ovr ? overrun_flag : recv_done_flag) !== 1'b1 && n < 3000) begin
         tick(1);
         n++;
      end
      cmp1(n < 3000, 1'b1);
   endtask

   // disable, change the clock setup while idle, enable both directions
   task automatic setup(input ssr_row_t s);
      recv_enable = 1'b0;
      xmit_enable = 1'b0;
      tick(2);
      clk_ext_sel  = s.ext;
      clk_polarity = s.pol;
      clk_div_sel  = s.div;
      tick(8);
      recv_enable = 1'b1;
      xmit_enable = 1'b1;
      tick(4);
   endtask

   // dummy byte into the transmit buffer, byte handed to the sender only when the external clock is selected
   task automatic xfer(input ssr_row_t s);
      dummy_data = s.dum;
      dummy_wr   = 1'b1;
      send_data  = s.tx;
      send_valid = s.ext;
      tick(1);
      dummy_wr   = 1'b0;
      send_valid = 1'b0;
   endtask

   task automatic pulse_rd(input logic ack);
      rbuf_rd = 1'b1;
      irq_ack = ack;
      tick(1);
      rbuf_rd = 1'b0;
      irq_ack = 1'b0;
      tick(1);
   endtask

   task automatic stop_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      {recv_enable, xmit_enable, clk_ext_sel, clk_polarity, dummy_wr} = 5'h00;
      {rbuf_rd, irq_ack, send_valid, clk_div_sel} = 5'h00;
      {rts_func_en, rts_disable, clk_multi_sel, peer_split_sel} = 4'h8;
      {dummy_data, send_data} = 16'h0000;
      rst_n = 1'b0;
      tick(8);
      rst_n = 1'b1;
      for (int i = 0; i < 6; i++) begin
         setup(rows[i]);
         if (rows[i].ext) cmp1(link_if.recv_ready_out, 1'b0);
         xfer(rows[i]);
         wait_flag(1'b0);
         tick(2);
         cmp8(rbuf_data, rows[i].tx);
         cmp8(in_cap, rows[i].tx);
         cmp8(out_cap, rows[i].dum);
         cmp1(recv_irq, 1'b1);
         cmp1(link_if.recv_ready_out, !rows[i].ext);
         pulse_rd(1'b1);
         cmp1(recv_done_flag, 1'b0);
      end
      r = rows[0];
      r.tx = 8'h22;
      setup(rows[0]);
      xfer(rows[0]);
      wait_flag(1'b0);
      irq_ack = 1'b1;
      tick(1);
      irq_ack = 1'b0;
      tick(4);
      xfer(r);
      wait_flag(1'b1);
      tick(2);
      cmp8(rbuf_data, 8'h22);
      cmp1(recv_irq, 1'b0);
      pulse_rd(1'b0);
      recv_enable = 1'b0;
      xmit_enable = 1'b0;
      tick(4);
      cmp1(link_if.recv_ready_out, 1'b1);
      cmp1(overrun_flag, 1'b0);
      recv_enable = 1'b1;
      tick(2);
      cmp1(link_if.recv_ready_out, 1'b0);
      rts_func_en = 1'b0;
      tick(2);
      cmp1(link_if.recv_ready_out, 1'b1);
      {rts_func_en, rts_disable} = 2'h3;
      tick(2);
      cmp1(link_if.recv_ready_out, 1'b1);
      {rts_disable, peer_split_sel, clk_multi_sel} = 3'h3;
      tick(2);
      cmp1(link_if.recv_ready_out, 1'b0);
      cmp1(link_if.clock_aux_out, 1'b1);
      recv_enable = 1'b0;
      clk_ext_sel = 1'b0;
      tick(4);
      cmp1(link_if.clock_aux_out, 1'b1);
      recv_enable = 1'b1;
      xfer(rows[2]);
      tick(100);
      cmp1(recv_done_flag, 1'b0);
      cmp1(tbuf_empty, 1'b0);
      xmit_enable = 1'b1;
      wait_flag(1'b0);
      tick(2);
      cmp8(out_cap, 8'h96);
      cmp1(tbuf_empty, 1'b1);
      setup(rows[1]);
      recv_enable = 1'b0;
      tick(8);
      xfer(rows[1]);
      tick(20);
      cmp1(send_ready, 1'b0);
      cmp1(link_if.tx_clk_out, 1'b0);
      recv_enable = 1'b1;
      tick(40);
      rst_n = 1'b0;
      tick(3);
      cmp8(rbuf_data, 8'h00);
      cmp1(link_if.recv_ready_out, 1'b1);
      cmp1(recv_done_flag, 1'b0);
      rst_n = 1'b1;
      tick(4);
      stop_test();
   end

   // watchdog against a hang
   initial begin
      #60us;
      error_cnt++;
      stop_test();
   end
endmodule
